// ===== rtl/lfc_oc_timer.sv
`timescale 1ns/1ps
// Per-channel overcurrent duration timer
module lfc_oc_timer
    import lfc_pkg::*;
#(
    parameter int LIMIT = OC_CYCLES  // Clocks of overcurrent before trip
) (
    input  wire logic clock_i,   // System clock
    input  wire logic rst_n_i,   // Async reset, active low
    input  wire logic enable_i,  // Channel output enabled
    input  wire logic over_i,    // Current above limit
    output logic      trip_o     // One-cycle trip pulse
);

    localparam int CW = $clog2(LIMIT + 1);

    // Refuse limits the counter cannot serve
    if (LIMIT < 2) begin : g_chk
        $error("lfc_oc_timer: LIMIT must be at least 2");
    end

    logic [CW-1:0] cnt;  // Consecutive overcurrent clocks

    // Count only an unbroken run of overcurrent
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt    <= '0;
            trip_o <= 1'b0;
        end else if (!(over_i && enable_i)) begin
            cnt    <= '0;  // Restart on any dip below the limit
            trip_o <= 1'b0;
        end else if (cnt == CW'(LIMIT - 1)) begin
            cnt    <= '0;
            trip_o <= 1'b1;  // Surge outlasted the window
        end else begin
            cnt    <= cnt + 1'b1;  // Surge still tolerated
            trip_o <= 1'b0;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Trip only after a full window of overcurrent
    trip_window_a: assert property (
        trip_o |-> $past(cnt) == CW'(LIMIT - 1) && $past(over_i))
        else $error("trip without full overcurrent window");
    // Counter restarts after a dip
    dip_restart_a: assert property (!over_i |=> cnt == '0)
        else $error("overcurrent count not restarted");

endmodule : lfc_oc_timer

// ===== rtl/lfc_pkg.sv
// Shared constants for the LNB fault timer and tone control block
package lfc_pkg;

    // Clock and derived rates
    localparam int CLK_HZ      = 100_000_000;  // System clock rate
    localparam int BOOST_HZ    = 352_000;      // Boost switching rate
    localparam int TONE_HZ     = 22_000;       // Tone oscillator rate
    localparam int TONE_MUL    = 16;           // Boost periods per tone period
    // Clocks between boost half-period ticks, rounded down
    localparam int HALF_TICK_CYC = CLK_HZ / (2 * BOOST_HZ);
    // Boost half ticks in one tone half period
    localparam int TONE_HALF_TICKS = TONE_MUL;
    // Detector release: one and a half tone periods in half ticks
    localparam int DET_TIMEOUT_TICKS = 3 * TONE_MUL;

    // Overcurrent disable time
    localparam int OC_TIME_MS  = 48;                           // Milliseconds
    localparam int OC_CYCLES   = OC_TIME_MS * (CLK_HZ / 1000); // Clocks

    // Structure
    localparam int NUM_CH      = 2;  // Channels
    localparam int AW          = 8;  // Register address width
    localparam int DW          = 8;  // Register data width

    // Register byte offsets
    localparam logic [AW-1:0] ADDR_CTRL     = 8'h00;  // Control
    localparam logic [AW-1:0] ADDR_STATUS   = 8'h04;  // Live status
    localparam logic [AW-1:0] ADDR_INT_STAT = 8'h08;  // Sticky events
    localparam logic [AW-1:0] ADDR_INT_CLR  = 8'h0c;  // Event clear
    localparam logic [AW-1:0] ADDR_INT_EN   = 8'h10;  // Event enable

    // Control fields, one bit per channel from the LSB given
    localparam int CTRL_EN_LSB   = 0;  // Channel enable
    localparam int CTRL_SRC_LSB  = 2;  // Tone source select
    localparam int CTRL_GATE_LSB = 4;  // Tone gate bit
    // Status fields
    localparam int STAT_OCP_LSB  = 0;  // Overcurrent latched
    localparam int STAT_TONE_DETECTED_FLAG_LSB = 2;  // Tone detected
    localparam int STAT_ON_LSB   = 4;  // Channel output on
    // Interrupt fields
    localparam int INT_OCP_LSB   = 0;  // Overcurrent trip event
    localparam int INT_TONE_LSB  = 2;  // Received tone start event
    localparam int INT_W         = 4;  // Interrupt register width

    // Reset values
    localparam logic [DW-1:0]    CTRL_RST   = 8'h00;
    localparam logic [INT_W-1:0] INT_EN_RST = 4'h0;

endpackage : lfc_pkg

// ===== rtl/lfc_tone_det.sv
`timescale 1ns/1ps
// Tone envelope detector on a squared tone input
module lfc_tone_det
    import lfc_pkg::*;
#(
    parameter int TIMEOUT = DET_TIMEOUT_TICKS  // Release time in ticks
) (
    input  wire logic clock_i,  // System clock
    input  wire logic rst_n_i,  // Async reset, active low
    input  wire logic tick_i,   // Time base enable pulse
    input  wire logic tone_i,   // Squared tone input
    output logic      env_o     // Tone envelope
);

    localparam int GW = $clog2(TIMEOUT + 1);

    // Refuse release times shorter than two ticks
    if (TIMEOUT < 2) begin : g_chk
        $error("lfc_tone_det: TIMEOUT must be at least 2");
    end

    logic          prev;  // Input one clock ago
    logic [GW-1:0] gap;   // Ticks since last rising edge

    // Rising edge opens the envelope, silence closes it
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev  <= 1'b0;
            gap   <= '0;
            env_o <= 1'b0;
        end else begin
            prev <= tone_i;
            if (tone_i && !prev) begin
                env_o <= 1'b1;  // Open within one clock of the edge
                gap   <= '0;
            end else if (env_o && tick_i) begin
                if (gap == GW'(TIMEOUT - 1)) begin
                    env_o <= 1'b0;  // Close soon after burst end
                end else begin
                    gap <= gap + 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Envelope follows the first edge at once
    env_open_a: assert property (tone_i && !prev |=> env_o)
        else $error("envelope late after tone edge");
    // Envelope closes after the release time
    env_close_a: assert property (
        env_o && tick_i && !(tone_i && !prev) && gap == GW'(TIMEOUT - 1)
        |=> !env_o)
        else $error("envelope not released");

endmodule : lfc_tone_det

// ===== rtl/lfc_top.sv
`timescale 1ns/1ps
module lfc_top
    import lfc_pkg::*;
#(
    parameter int OC_LIMIT = OC_CYCLES  // Overcurrent clocks before trip
) (
    input  wire logic              clock_i,          // System clock
    input  wire logic              rst_n_i,          // Async reset
    input  wire logic [AW-1:0]     reg_addr_i,       // Register address
    input  wire logic [DW-1:0]     reg_wdata_i,      // Write data
    input  wire logic              reg_wr_i,         // Write strobe
    input  wire logic              reg_rd_i,         // Read strobe
    output logic      [DW-1:0]     reg_rdata_o,      // Read data
    output logic                   irq_o,            // Interrupt level
    input  wire logic [NUM_CH-1:0] overcurrent_i,    // Current above limit
    input  wire logic [NUM_CH-1:0] external_modulation_pin_i, // Ext tone
    input  wire logic [NUM_CH-1:0] tone_rx_i,        // Squared coax tone
    output logic      [NUM_CH-1:0] channel_enable_o, // Output stage on
    output logic      [NUM_CH-1:0] tone_tx_o,        // Tone to modulator
    output logic                   boost_clk_o,      // Boost switch clock
    output logic      [NUM_CH-1:0] tone_det_out_o,   // Open-drain level
    output logic      [NUM_CH-1:0] tone_det_oe_n_o   // Low while driving
);

    // Refuse a window the timer cannot count
    if (OC_LIMIT < 2) begin : g_chk
        $error("lfc_top: OC_LIMIT must be at least 2");
    end

    localparam int HW = $clog2(HALF_TICK_CYC);
    localparam int TW = $clog2(TONE_HALF_TICKS);

    // Control and status state
    logic [NUM_CH-1:0] tone_source_select;       // 1 internal, 0 pin
    logic [NUM_CH-1:0] tone_gate_bit;            // Tone gate
    logic [NUM_CH-1:0] overcurrent_latched_flag; // Latched trip
    logic [NUM_CH-1:0] tone_detected_flag;       // Tone seen or sent
    logic [INT_W-1:0]  int_stat;                 // Sticky events
    logic [INT_W-1:0]  int_en;                   // Event enables
    logic [INT_W-1:0]  int_ev;                   // Events this clock

    // Rate generation
    logic [HW-1:0]     half_cnt;  // Clocks to next half tick
    logic              half_tick; // Boost half-period pulse
    logic [TW-1:0]     tone_cnt;  // Half ticks to next tone edge
    logic              int_tone;  // Internal tone square wave

    // Per-channel links
    logic [NUM_CH-1:0] trip;       // Overcurrent trip pulses
    logic [NUM_CH-1:0] rx_env;     // Received tone envelope
    logic [NUM_CH-1:0] rx_env_d;   // Envelope one clock ago
    logic [NUM_CH-1:0] ext_env;    // Activity on modulation pin
    logic [NUM_CH-1:0] tx_active;  // A tone is being sent
    logic [NUM_CH-1:0] next_tx;    // Tone output next value

    // Register strobes
    logic wr_ctrl;  // Control write
    logic wr_clr;   // Event clear write
    logic wr_en;    // Event enable write

    assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_CTRL);
    assign wr_clr  = reg_wr_i && (reg_addr_i == ADDR_INT_CLR);
    assign wr_en   = reg_wr_i && (reg_addr_i == ADDR_INT_EN);

    // Boost half-period divider
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            half_cnt  <= '0;
            half_tick <= 1'b0;
        end else if (half_cnt == HW'(HALF_TICK_CYC - 1)) begin
            half_cnt  <= '0;
            half_tick <= 1'b1;
        end else begin
            half_cnt  <= half_cnt + 1'b1;
            half_tick <= 1'b0;
        end
    end

    // Boost clock toggles each half tick
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boost_clk_o <= 1'b0;
        end else if (half_tick) begin
            boost_clk_o <= ~boost_clk_o;
        end
    end

    // Tone derived from the boost clock, sixteen periods per tone
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tone_cnt <= '0;
            int_tone <= 1'b0;
        end else if (half_tick) begin
            if (tone_cnt == TW'(TONE_HALF_TICKS - 1)) begin
                tone_cnt <= '0;
                int_tone <= ~int_tone;
            end else begin
                tone_cnt <= tone_cnt + 1'b1;
            end
        end
    end

    // Per-channel timer and detectors
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        // Overcurrent duration timer
        lfc_oc_timer #(
            .LIMIT   (OC_LIMIT)
        ) u_oc (
            .clock_i (clock_i),
            .rst_n_i (rst_n_i),
            .enable_i(channel_enable_o[c]),
            .over_i  (overcurrent_i[c]),
            .trip_o  (trip[c])
        );
        // Coax tone detector
        lfc_tone_det #(
            .TIMEOUT (DET_TIMEOUT_TICKS)
        ) u_rx (
            .clock_i (clock_i),
            .rst_n_i (rst_n_i),
            .tick_i  (half_tick),
            .tone_i  (tone_rx_i[c]),
            .env_o   (rx_env[c])
        );
        // Activity detector on the modulation pin
        lfc_tone_det #(
            .TIMEOUT (DET_TIMEOUT_TICKS)
        ) u_ext (
            .clock_i (clock_i),
            .rst_n_i (rst_n_i),
            .tick_i  (half_tick),
            .tone_i  (external_modulation_pin_i[c]),
            .env_o   (ext_env[c])
        );
    end

    // Transmit option decode
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (tone_source_select[c]) begin
                // Internal oscillator gated by bit and pin
                next_tx[c]   = int_tone & tone_gate_bit[c]
                             & external_modulation_pin_i[c];
                tx_active[c] = tone_gate_bit[c]
                             & external_modulation_pin_i[c];
            end else begin
                // Pin carries the tone, gated by the bit
                next_tx[c]   = tone_gate_bit[c]
                             & external_modulation_pin_i[c];
                tx_active[c] = tone_gate_bit[c] & ext_env[c];
            end
        end
    end

    // Tone output to the modulator
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tone_tx_o <= '0;
        end else begin
            tone_tx_o <= next_tx;
        end
    end

    // Open-drain tone detector pins, pulled low while tone present
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tone_det_out_o  <= '0;
            tone_det_oe_n_o <= '1;
            rx_env_d        <= '0;
        end else begin
            tone_det_out_o  <= '0;
            tone_det_oe_n_o <= ~rx_env;
            rx_env_d        <= rx_env;
        end
    end

    // Tone detected flag, live
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tone_detected_flag <= '0;
        end else begin
            tone_detected_flag <= rx_env | tx_active;
        end
    end

    // Channel enable and overcurrent latch
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            channel_enable_o         <= CTRL_RST[CTRL_EN_LSB +: NUM_CH];
            overcurrent_latched_flag <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (trip[c]) begin
                    // Trip beats a same-clock write
                    channel_enable_o[c]         <= 1'b0;
                    overcurrent_latched_flag[c] <= 1'b1;
                end else if (wr_ctrl) begin
                    // Only software turns the channel back on
                    channel_enable_o[c] <= reg_wdata_i[CTRL_EN_LSB + c];
                    if (reg_wdata_i[CTRL_EN_LSB + c]) begin
                        overcurrent_latched_flag[c] <= 1'b0;
                    end
                end
            end
        end
    end

    // Tone source and gate control bits
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tone_source_select <= CTRL_RST[CTRL_SRC_LSB +: NUM_CH];
            tone_gate_bit      <= CTRL_RST[CTRL_GATE_LSB +: NUM_CH];
        end else if (wr_ctrl) begin
            tone_source_select <= reg_wdata_i[CTRL_SRC_LSB +: NUM_CH];
            tone_gate_bit      <= reg_wdata_i[CTRL_GATE_LSB +: NUM_CH];
        end
    end

    // Events: trips and start of received tone
    always_comb begin
        int_ev = '0;
        int_ev[INT_OCP_LSB +: NUM_CH]  = trip;
        int_ev[INT_TONE_LSB +: NUM_CH] = rx_env & ~rx_env_d;
    end

    // Sticky status, set wins over clear
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_stat <= '0;
        end else if (wr_clr) begin
            int_stat <= (int_stat & ~reg_wdata_i[INT_W-1:0]) | int_ev;
        end else begin
            int_stat <= int_stat | int_ev;
        end
    end

    // Enable register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_en <= INT_EN_RST;
        end else if (wr_en) begin
            int_en <= reg_wdata_i[INT_W-1:0];
        end
    end

    // Interrupt level
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(int_stat & int_en);
        end
    end

    // Read data for one clock after the strobe, zero otherwise
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= '0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    ADDR_CTRL: begin
                        reg_rdata_o[CTRL_EN_LSB +: NUM_CH]   <=
                            channel_enable_o;
                        reg_rdata_o[CTRL_SRC_LSB +: NUM_CH]  <=
                            tone_source_select;
                        reg_rdata_o[CTRL_GATE_LSB +: NUM_CH] <=
                            tone_gate_bit;
                    end
                    ADDR_STATUS: begin
                        reg_rdata_o[STAT_OCP_LSB +: NUM_CH]  <=
                            overcurrent_latched_flag;
                        reg_rdata_o[STAT_TONE_DETECTED_FLAG_LSB +: NUM_CH] <=
                            tone_detected_flag;
                        reg_rdata_o[STAT_ON_LSB +: NUM_CH]   <=
                            channel_enable_o;
                    end
                    ADDR_INT_STAT: reg_rdata_o[INT_W-1:0] <= int_stat;
                    ADDR_INT_EN:   reg_rdata_o[INT_W-1:0] <= int_en;
                    default:       reg_rdata_o <= '0;  // Unmapped, clear
                endcase
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Trip disables the channel and latches the flag
    trip_shutdown_a: assert property (
        trip[0] |=> !channel_enable_o[0] && overcurrent_latched_flag[0])
        else $error("trip did not shut channel 0");
    // Latch holds until software enables again
    latch_hold_a: assert property (
        overcurrent_latched_flag[0] && !wr_ctrl
        |=> overcurrent_latched_flag[0])
        else $error("overcurrent latch dropped by itself");
    // Boost edges fall only on half ticks
    boost_edge_a: assert property (
        $changed(boost_clk_o) |-> $past(half_tick))
        else $error("boost clock edge off the divider");
    // Tone edges come with a boost falling edge
    tone_ratio_a: assert property (
        $changed(int_tone) |-> $changed(boost_clk_o) && !boost_clk_o
        && $past(tone_cnt) == TW'(TONE_HALF_TICKS - 1))
        else $error("tone not sixteen boost periods");
    // Detector pin pulls low two clocks after a coax edge
    det_pin_a: assert property (
        $rose(tone_rx_i[1]) |=> ##1 !tone_det_oe_n_o[1])
        else $error("tone pin not pulled low");
    // Source select with gate low sends nothing
    gate_off_a: assert property (
        !tone_gate_bit[0] |=> !tone_tx_o[0])
        else $error("tone sent with gate low");
    // External source passes the pin when gated on
    ext_pass_a: assert property (
        !tone_source_select[1] && tone_gate_bit[1]
        && external_modulation_pin_i[1] |=> tone_tx_o[1])
        else $error("external tone not passed");
    // Internal source follows the oscillator
    int_src_a: assert property (
        tone_source_select[0] && tone_gate_bit[0]
        && external_modulation_pin_i[0] |=> tone_tx_o[0] == $past(int_tone))
        else $error("internal tone not passed");
    // Transmitting sets the tone flag
    tx_flag_a: assert property (
        tx_active[1] |=> tone_detected_flag[1])
        else $error("tone flag not set while sending");

    // Scenarios of interest
    trip_seen_c: cover property (trip[0] ##[1:20] wr_clr);
    rx_tone_c: cover property ($rose(rx_env[1]) ##1 !tone_det_oe_n_o[1]);
    irq_raise_c: cover property ($rose(irq_o));
    ext_tone_c: cover property (tx_active[0] && !tone_source_select[0]);

endmodule : lfc_top

// ===== verification/lfc_lnb_model.sv
`timescale 1ns/1ps
// Behavioural LNB on the coax: load current and tone reply
module lfc_lnb_model
    import lfc_pkg::*;
(
    input  wire logic              clock_i,   // System clock
    input  wire logic [NUM_CH-1:0] powered_i, // Channel output on
    output logic      [NUM_CH-1:0] over_o,    // Load above limit
    output logic      [NUM_CH-1:0] tone_o     // Squared tone reply
);
    localparam int HALF = TONE_MUL * HALF_TICK_CYC; // Tone half period
    logic [NUM_CH-1:0] short_q = '0;                // Shorted load
    // A dead channel draws no current, so no overcurrent either
    assign over_o = short_q & powered_i;
    // Line idles low outside bursts
    initial tone_o = '0;
    // Short a channel for a number of clocks
    task automatic surge(input int ch, input int n);
        short_q[ch] <= 1'b1;
        repeat (n) @(posedge clock_i);
        short_q[ch] <= 1'b0;
    endtask : surge
    // Whole tone cycles, ending low
    task automatic burst(input int ch, input int cyc);
        repeat (2 * cyc) begin
            tone_o[ch] <= ~tone_o[ch];
            repeat (HALF) @(posedge clock_i);
        end
    endtask : burst
endmodule : lfc_lnb_model

// ===== verification/test_lfc_top.sv
`timescale 1ns/1ps
// Self-checking bench for the LNB fault timer and tone block
module test_lfc_top import lfc_pkg::*;;
    localparam int LIM = 50;                       // Shortened trip count
    localparam int GAP = 1000;                     // Scaled restart gap
    localparam int TH  = TONE_MUL * HALF_TICK_CYC; // Tone half period
    logic              clock_i     = 1'b0;  // 100 MHz clock
    logic              rst_n_i     = 1'b0;  // Reset, active low
    logic [AW-1:0]     reg_addr_i  = '0;    // Register address
    logic [DW-1:0]     reg_wdata_i = '0;    // Write data
    logic              reg_wr_i    = 1'b0;  // Write strobe
    logic              reg_rd_i    = 1'b0;  // Read strobe
    logic [DW-1:0]     reg_rdata_o;         // Read data
    logic              irq_o;               // Interrupt level
    logic              boost_o;             // Boost clock
    logic [NUM_CH-1:0] over, rx, en_o, tx_o, det_o, oe_n_o; // Channel pins
    logic              ext_src = 1'b0;      // Pin held as level
    logic              ext_run = 1'b0;      // Pin active
    logic              ext_sq  = 1'b0;      // Pin square wave
    logic              sel     = 1'b0;      // Probe picks tone output
    int                ext_cnt = 0;         // Square wave divider
    int                err_total  = 0;      // Mismatches
    int                num_checks = 0;      // Comparisons
    logic [3:0]        opt [6] = '{4'hf, 4'ha, 4'hc, 4'h7, 4'h2, 4'h4};
    wire pin   = ext_run & (ext_src | ext_sq);  // Modulation pin level
    wire probe = sel ? tx_o[0] : boost_o;       // Signal under timing
    // Clock and modulation pin square wave
    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        ext_cnt <= (ext_cnt == TH - 1) ? 0 : ext_cnt + 1;
        if (ext_cnt == 0) ext_sq <= ~ext_sq;
    end
    lfc_top #(.OC_LIMIT(LIM)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .irq_o(irq_o), .overcurrent_i(over), .tone_rx_i(rx),
        .external_modulation_pin_i({2{pin}}), .channel_enable_o(en_o),
        .tone_tx_o(tx_o), .boost_clk_o(boost_o), .tone_det_out_o(det_o),
        .tone_det_oe_n_o(oe_n_o));
    lfc_lnb_model lnb (.clock_i(clock_i), .powered_i(en_o), .over_o(over),
        .tone_o(rx));
    // Exact value compare
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Count within bounds
    task automatic chk_in(input string nm, input int lo, hi, g);
        num_checks++;
        if (g < lo || g > hi) begin
            err_total++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_in
    // One write cycle
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clock_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clock_i);
        reg_wr_i    <= 1'b0;
    endtask : wr
    // Read cycle, data taken in the following cycle
    task automatic rchk(input string nm, input logic [AW-1:0] a,
                        input logic [DW-1:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clock_i);
        reg_rd_i   <= 1'b0;
        #1 chk(nm, e, reg_rdata_o);
    endtask : rchk
    // Clocks between two changes of the probe
    task automatic gap(output int n);
        logic v;
        @(posedge clock_i) v = probe;
        for (n = 0; n < 9999 && probe === v; n++) @(posedge clock_i);
        v = probe;
        for (n = 0; n < 9999 && probe === v; n++) @(posedge clock_i);
    endtask : gap
    // Reset values, refused accesses
    task automatic t_reset();
        chk("outputs", 8'h30, {2'h0, oe_n_o, en_o, irq_o, reg_rdata_o[0]});
        rchk("ctrl", ADDR_CTRL, CTRL_RST);
        rchk("int en", ADDR_INT_EN, {4'h0, INT_EN_RST});
        rchk("clear reg", ADDR_INT_CLR, 8'h00);
        wr(8'h14, 8'hff);
        wr(ADDR_STATUS, 8'hff);
        rchk("unmapped", 8'h14, 8'h00);
        rchk("ctrl kept", ADDR_CTRL, 8'h00);
        rchk("status", ADDR_STATUS, 8'h00);
    endtask : t_reset
    // Surges, trip, masking, clearing and restart
    task automatic t_overcurrent();
        int n;
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_INT_EN, 8'h01);
        lnb.surge(0, LIM - 1);
        @(posedge clock_i);
        lnb.surge(0, LIM - 1);
        repeat (4) @(posedge clock_i);
        chk("surge", 2'b01, en_o);
        fork
            lnb.surge(0, 4 * LIM);
        join_none
        for (n = 0; n < 999 && en_o[0] === 1'b1; n++) @(posedge clock_i);
        chk_in("trip", LIM, LIM + 3, n);
        rchk("tripped", ADDR_STATUS, 8'h01);
        rchk("trip event", ADDR_INT_STAT, 8'h01);
        chk("irq", 1'b1, irq_o);
        wr(ADDR_INT_EN, 8'h00);
        repeat (2) @(posedge clock_i);
        chk("irq masked", 1'b0, irq_o);
        wr(ADDR_INT_EN, 8'h01);
        wr(ADDR_INT_CLR, 8'h01);
        rchk("cleared", ADDR_INT_STAT, 8'h00);
        chk("irq cleared", 1'b0, irq_o);
        repeat (GAP) @(posedge clock_i);
        rchk("held off", ADDR_STATUS, 8'h01);
        wr(ADDR_CTRL, 8'h01);
        rchk("restart", ADDR_STATUS, 8'h10);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_INT_EN, 8'h00);
    endtask : t_overcurrent
    // Boost half period and internal tone half period
    task automatic t_boost();
        int n;
        ext_src <= 1'b1;
        ext_run <= 1'b1;
        wr(ADDR_CTRL, 8'h14);
        gap(n);
        chk("boost half", HALF_TICK_CYC, n);
        sel <= 1'b1;
        gap(n);
        chk("tone half", TH, n);
    endtask : t_boost
    // One source, gate and pin setting
    task automatic t_option(input logic s, g, r, x);
        int n;
        logic v;
        wr(ADDR_CTRL, {2'h0, g, g, s, s, 2'h0});
        ext_src <= s;
        ext_run <= r;
        repeat (2) @(posedge clock_i);
        v = tx_o[0];
        n = 0;
        repeat (7500) begin
            @(posedge clock_i);
            if (tx_o[0] !== v) n++;
            v = tx_o[0];
        end
        chk("tone sent", x, n > 0);
        rchk("tone flag", ADDR_STATUS, {4'h0, x, x, 2'h0});
    endtask : t_option
    // Received burst on the second channel
    task automatic t_rx();
        int n;
        int m;
        wr(ADDR_INT_EN, 8'h08);
        fork
            lnb.burst(1, 5);
        join_none
        for (n = 0; n < 9999 && oe_n_o[1] === 1'b1; n++) @(posedge clock_i);
        chk_in("lag", 0, 2 * TH, n);
        chk("pins", 3'h4, {oe_n_o[0], det_o});
        for (m = 0; m < 99999 && oe_n_o[1] === 1'b0; m++) @(posedge clock_i);
        chk_in("burst", 8 * TH, 12 * TH, m);
        rchk("tone event", ADDR_INT_STAT, 8'h08);
        chk("irq tone", 1'b1, irq_o);
        wr(ADDR_INT_CLR, 8'h08);
        rchk("tone cleared", ADDR_INT_STAT, 8'h00);
    endtask : t_rx
    // Counts and verdict
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_overcurrent();
        t_boost();
        for (int i = 0; i < 6; i++) begin
            t_option(opt[i][3], opt[i][2], opt[i][1], opt[i][0]);
        end
        t_rx();
        final_report();
    end
    // Hang guard
    initial begin
        repeat (95000) @(posedge clock_i);
        err_total++;
        final_report();
    end
endmodule : test_lfc_top
